/* hdl/lns_device.sv */
// Device end: lamp shadow registers and negotiation status views
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Bit 15 set writes shadow, clear selects
// - Select write, then read returns shadow bits
// - Code 01110 reaches lamp source selector
// - Code 01111 reaches lamp pin control
// - Lamp four source field, default interrupt
// - Lamp three source field, default activity
// - Lamp bits 9:8 reserved, written zero
// - Bits 7:4 report lamp pin direction
// - Bits 3:0 disable lamp outputs, reset zero
// - 1Dh bit 15 chooses seed or resolution
// - One write selects view; a seed-view write also updates the seed
// - Seed match flag latches high
// - Bit 13 reports partner port type
// - Bit 12 reports partner manual role
// - Bit 11 reports partner manual enable
// - Bits 10:0 return local seed, reset zero
// - Bits 11:6 latch resolved modes
// - Resolution bits 14:12 reserved zero
// - Bits 5:0 latch link-failure flags
// - Negotiation off or restart clears flags
module lns_device
	import lns_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	lns_if.device bus,
	input wire logic [3:0] i_lamp_pin_is_input,
	input wire logic i_seed_match,
	input wire logic i_partner_repeater,
	input wire logic i_partner_master,
	input wire logic i_partner_manual_en,
	input wire logic [10:0] i_local_seed,
	input wire logic i_seed_load,
	input wire logic [LNS_RES_MODES-1:0] i_resolved,
	input wire logic [LNS_RES_MODES-1:0] i_resolved_no_link,
	input wire logic i_aneg_clear,
	output logic [3:0] o_lamp_four_source,
	output logic [3:0] o_lamp_three_source,
	output logic [3:0] o_lamp_output_disable
);
	logic [4:0] shadow_ptr;
	logic [3:0] lamp_four_src;
	logic [3:0] lamp_three_src;
	logic [3:0] lamp_dis;
	logic view_res;
	logic [10:0] seed;
	logic seed_match_flag;
	logic [2*LNS_RES_MODES-1:0] res_flags;
	logic [3:0] dir_m;
	logic [3:0] dir_r;
	logic [4:0] part_m;
	logic [4:0] part_r;
	logic [LNS_DATA_W-1:0] rdata;
	logic wr_shadow;
	logic wr_seed;
	logic rd_seed;

	assign wr_shadow = bus.wr && bus.addr == LNS_ADDR_SHADOW;
	assign wr_seed = bus.wr && bus.addr == LNS_ADDR_SEED;
	assign rd_seed = bus.rd && bus.addr == LNS_ADDR_SEED;
	assign bus.rdata = rdata;

	////////////////////////////////////////////////////////////////////////
	// Pin and partner inputs come from other logic; two flops each
	always_ff @(posedge i_clk) begin
		dir_m <= i_lamp_pin_is_input;
		dir_r <= dir_m;
		part_m <= {i_seed_match, i_partner_repeater, i_partner_master,
			i_partner_manual_en, i_seed_load};
		part_r <= part_m;
	end

	////////////////////////////////////////////////////////////////////////
	// shadow pointer only moves on select writes
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			shadow_ptr <= LNS_SHADOW_LAMP_SEL;
		end else if (wr_shadow && !bus.wdata[LNS_WE_BIT]) begin
			shadow_ptr <= bus.wdata[LNS_SEL_HI:LNS_SEL_LO];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			lamp_four_src <= LNS_LAMP4_RESET;
			lamp_three_src <= LNS_LAMP3_RESET;
		end else if (wr_shadow && bus.wdata[LNS_WE_BIT]
				&& bus.wdata[LNS_SEL_HI:LNS_SEL_LO] == LNS_SHADOW_LAMP_SEL) begin
			lamp_four_src <= bus.wdata[7:4];
			lamp_three_src <= bus.wdata[3:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			lamp_dis <= LNS_LAMP_DIS_RESET;
		end else if (wr_shadow && bus.wdata[LNS_WE_BIT]
				&& bus.wdata[LNS_SEL_HI:LNS_SEL_LO] == LNS_SHADOW_LAMP_DIR) begin
			lamp_dis <= bus.wdata[3:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_lamp_four_source <= LNS_LAMP4_RESET;
			o_lamp_three_source <= LNS_LAMP3_RESET;
			o_lamp_output_disable <= LNS_LAMP_DIS_RESET;
		end else begin
			o_lamp_four_source <= lamp_four_src;
			o_lamp_three_source <= lamp_three_src;
			o_lamp_output_disable <= lamp_dis;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// view follows bit 15 of every 1Dh write
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			view_res <= 1'b0;
		end else if (wr_seed) begin
			view_res <= bus.wdata[LNS_WE_BIT];
		end
	end

	// seed loads from the generator; a seed-view write also lands
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			seed <= LNS_SEED_RESET;
		end else if (wr_seed && !bus.wdata[LNS_WE_BIT]) begin
			seed <= bus.wdata[10:0];
		end else if (part_r[0]) begin
			seed <= i_local_seed;
		end
	end

	// set wins over clear on read
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			seed_match_flag <= 1'b0;
		end else if (part_r[4]) begin
			seed_match_flag <= 1'b1;
		end else if (rd_seed && !view_res) begin
			seed_match_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset || i_aneg_clear) begin
			res_flags <= '0;
		end else if (rd_seed && view_res) begin
			res_flags <= {i_resolved, i_resolved_no_link};
		end else begin
			res_flags <= res_flags | {i_resolved, i_resolved_no_link};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data one cycle later
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rdata <= '0;
		end else if (bus.rd) begin
			rdata <= '0;
			if (bus.addr == LNS_ADDR_SHADOW) begin
				rdata[LNS_SEL_HI:LNS_SEL_LO] <= shadow_ptr;
				if (shadow_ptr == LNS_SHADOW_LAMP_SEL) begin
					rdata[7:0] <= {lamp_four_src, lamp_three_src};
				end else if (shadow_ptr == LNS_SHADOW_LAMP_DIR) begin
					rdata[7:0] <= {dir_r, lamp_dis};
				end
			end else if (bus.addr == LNS_ADDR_SEED) begin
				rdata[LNS_WE_BIT] <= view_res;
				if (view_res) begin
					rdata[2*LNS_RES_MODES-1:0] <= res_flags;
				end else begin
					rdata[LNS_MATCH_BIT] <= seed_match_flag;
					rdata[LNS_RPT_BIT] <= part_r[3];
					rdata[LNS_MSVAL_BIT] <= part_r[2];
					rdata[LNS_MSEN_BIT] <= part_r[1];
					rdata[10:0] <= seed;
				end
			end
		end
	end
endmodule // lns_device
`default_nettype wire

/* hdl/lns_if.sv */
// Management register port joining manager and device
`timescale 1ns/10ps
`default_nettype none
interface lns_if;
	import lns_pkg::*;
	logic [LNS_ADDR_W-1:0] addr;
	logic [LNS_DATA_W-1:0] wdata;
	logic wr;
	logic rd;
	logic [LNS_DATA_W-1:0] rdata;
	modport device (input addr, input wdata, input wr, input rd, output rdata);
	modport manager (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

/* hdl/lns_manager.sv */
// Manager end: drives single-cycle register commands onto the port
`timescale 1ns/10ps
`default_nettype none
module lns_manager
	import lns_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	lns_if.manager bus,
	input wire logic i_cmd_wr,
	input wire logic i_cmd_rd,
	input wire logic [LNS_ADDR_W-1:0] i_cmd_addr,
	input wire logic [LNS_DATA_W-1:0] i_cmd_wdata,
	output logic o_rd_valid,
	output logic [LNS_DATA_W-1:0] o_rd_data
);
	logic [LNS_ADDR_W-1:0] addr;
	logic [LNS_DATA_W-1:0] wdata;
	logic wr;
	logic rd;
	logic rd_wait;

	assign bus.addr = addr;
	assign bus.wdata = wdata;
	assign bus.wr = wr;
	assign bus.rd = rd;

	// reserved bits always written as zero
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			addr <= '0;
			wdata <= '0;
			wr <= 1'b0;
			rd <= 1'b0;
		end else begin
			wr <= i_cmd_wr;
			rd <= i_cmd_rd && !i_cmd_wr;
			addr <= i_cmd_addr;
			wdata <= i_cmd_wdata;
			if (i_cmd_addr == LNS_ADDR_SHADOW) begin
				wdata[9:8] <= 2'h0;
			end else if (i_cmd_addr == LNS_ADDR_SEED && i_cmd_wdata[LNS_WE_BIT]) begin
				wdata[LNS_SEL_HI:12] <= 3'h0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rd_wait <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end else begin
			rd_wait <= rd;
			o_rd_valid <= rd_wait;
			if (rd_wait) begin
				o_rd_data <= bus.rdata;
			end
		end
	end
endmodule // lns_manager
`default_nettype wire

/* hdl/lns_pkg.sv */
// Constants shared by the lamp and negotiation status register ends
package lns_pkg;
	localparam int LNS_ADDR_W = 5;
	localparam int LNS_DATA_W = 16;
	localparam logic [4:0] LNS_ADDR_SHADOW = 5'h1c;
	localparam logic [4:0] LNS_ADDR_SEED = 5'h1d;
	localparam int LNS_WE_BIT = 15;
	localparam int LNS_SEL_HI = 14;
	localparam int LNS_SEL_LO = 10;
	localparam logic [4:0] LNS_SHADOW_LAMP_SEL = 5'h0e;
	localparam logic [4:0] LNS_SHADOW_LAMP_DIR = 5'h0f;
	localparam logic [3:0] LNS_LAMP4_RESET = 4'h6;
	localparam logic [3:0] LNS_LAMP3_RESET = 4'h3;
	localparam logic [3:0] LNS_LAMP_DIS_RESET = 4'h0;
	localparam logic [10:0] LNS_SEED_RESET = 11'h000;
	localparam int LNS_MATCH_BIT = 14;
	localparam int LNS_RPT_BIT = 13;
	localparam int LNS_MSVAL_BIT = 12;
	localparam int LNS_MSEN_BIT = 11;
	localparam int LNS_RES_MODES = 6;
	localparam int LNS_RES_OK_LO = 6;
	// Lamp source codes
	localparam logic [3:0] LNS_SRC_SPEED1 = 4'h0;
	localparam logic [3:0] LNS_SRC_SPEED2 = 4'h1;
	localparam logic [3:0] LNS_SRC_TX = 4'h2;
	localparam logic [3:0] LNS_SRC_ACT = 4'h3;
	localparam logic [3:0] LNS_SRC_DUPLEX = 4'h4;
	localparam logic [3:0] LNS_SRC_SLAVE = 4'h5;
	localparam logic [3:0] LNS_SRC_INTERRUPT_LAMP = 4'h6;
	localparam logic [3:0] LNS_SRC_RFAULT = 4'h7;
	localparam logic [3:0] LNS_SRC_RX = 4'h8;
	localparam logic [3:0] LNS_SRC_MULTI = 4'ha;
	localparam logic [3:0] LNS_SRC_CABLE = 4'hb;
	localparam logic [3:0] LNS_SRC_OFF = 4'he;
	localparam logic [3:0] LNS_SRC_ON = 4'hf;
endpackage

/* tb/lns_assertions.sv */
// Bus checks between manager and device ends
`timescale 1ns/10ps
`default_nettype none
module lns_assertions
	import lns_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [LNS_ADDR_W-1:0] addr,
	input wire logic [LNS_DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [LNS_DATA_W-1:0] rdata
);
	logic [4:0] ptr;
	logic [7:0] sel;
	logic [3:0] dis;
	logic view;
	wire wsh = wr && addr == LNS_ADDR_SHADOW;
	// Shadow of what the manager has written, to judge every read
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ptr <= LNS_SHADOW_LAMP_SEL;
			sel <= 8'h63;
			dis <= 4'h0;
			view <= 1'b0;
		end else begin
			if (wsh && !wdata[15])
				ptr <= wdata[14:10];
			if (wsh && wdata[15:10] == 6'h2e)
				sel <= wdata[7:0];
			if (wsh && wdata[15:10] == 6'h2f)
				dis <= wdata[3:0];
			if (wr && addr == LNS_ADDR_SEED)
				view <= wdata[15];
		end
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence rd_sh; rd && addr == LNS_ADDR_SHADOW; endsequence
	sequence rd_sd; rd && addr == LNS_ADDR_SEED; endsequence
	sequence pick_sel; wsh && wdata[15:10] == 6'h0e; endsequence
	ptr_read_a: assert property (rd_sh |=> rdata[15:10] == {1'b0, ptr})
		else $error("bad shadow pointer");
	lamp_sel_a: assert property (rd_sh ##0 ptr == 5'h0e |=> rdata[7:0] == sel)
		else $error("bad lamp source");
	lamp_dis_a: assert property (rd_sh ##0 ptr == 5'h0f |=> rdata[3:0] == dis)
		else $error("bad lamp disable");
	other_code_a: assert property (rd_sh ##0 ptr[4:1] != 4'h7 |=> rdata[9:0] == 10'h0)
		else $error("foreign shadow data");
	view_bit_a: assert property (rd_sd |=> rdata[15] == view)
		else $error("bad view bit");
	res_rsvd_a: assert property (rd_sd ##0 view |=> rdata[14:12] == 3'h0)
		else $error("reserved bits set");
	one_strobe_a: assert property (!(wr && rd))
		else $error("both strobes high");
	sel_kept_a: assert property (pick_sel ##[1:2] rd_sh |=> rdata[7:0] == sel)
		else $error("select changed source");
endmodule // lns_assertions
`default_nettype wire

/* tb/testbench.sv */
// Bench joining manager and device ends over the register port
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import lns_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic cw = 1'b0, cr = 1'b0, sm = 1'b0, rep = 1'b0, mst = 1'b0, men = 1'b0, clr = 1'b0, ov;
	logic [4:0] ca = 5'h00;
	logic [15:0] cd = 16'h0000, r = 16'h0000, rdat, od;
	logic [3:0] pin = 4'h0, o4, o3, odis;
	logic [5:0] res = 6'h00, nol = 6'h00;
	logic ld = 1'b0;
	logic [10:0] ls = 11'h000;
	logic [7:0] v;
	int err_total = 0, checked = 0, seed = 53, cyc = 0;
	lns_if bus_if();
	lns_manager lns_manager_inst(.i_clk(i_clk), .i_reset(i_reset), .bus(bus_if), .i_cmd_wr(cw),
		.i_cmd_rd(cr), .i_cmd_addr(ca), .i_cmd_wdata(cd), .o_rd_valid(ov), .o_rd_data(od));
	lns_device lns_device_inst(.i_clk(i_clk), .i_reset(i_reset), .bus(bus_if),
		.i_lamp_pin_is_input(pin), .i_seed_match(sm), .i_partner_repeater(rep),
		.i_partner_master(mst), .i_partner_manual_en(men), .i_local_seed(ls),
		.i_seed_load(ld), .i_resolved(res), .i_resolved_no_link(nol), .i_aneg_clear(clr),
		.o_lamp_four_source(o4), .o_lamp_three_source(o3), .o_lamp_output_disable(odis));
	lns_assertions lns_assertions_inst(.i_clk(i_clk), .i_reset(i_reset), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));
	always #2.5 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One command; a read waits a bounded time for the answer
	task automatic cmd(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk);
		cw <= w;
		cr <= !w;
		ca <= a;
		cd <= d;
		@(posedge i_clk);
		cw <= 1'b0;
		cr <= 1'b0;
		for (int k = 0; k < 6 && !w && ov !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		rdat = od;
	endtask
	function automatic logic [15:0] sh(input logic [4:0] c, input logic [7:0] x);
		return {1'b0, c, 2'b00, x};
	endfunction
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			complete_run;
		end
	end
	////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		cmd(1'b0, LNS_ADDR_SHADOW, 16'h0000);
		chk("reset lamp", rdat & 16'hfcff, sh(5'h0e, 8'h63));
		chk("reset pins", {4'h0, o4, o3, odis}, 16'h0630);
		$display("reset test done");
		for (int i = 0; i < 16; i++) begin
			v = {i[3:0], ~i[3:0]};
			cmd(1'b1, LNS_ADDR_SHADOW, sh(5'h0e, v) | 16'h8000);
			cmd(1'b0, LNS_ADDR_SHADOW, 16'h0000);
			chk("lamp source", rdat & 16'hfcff, sh(5'h0e, v));
			chk("lamp pins", {8'h00, o4, o3}, {8'h00, v});
		end
		$display("source test done");
		for (int i = 0; i < 8; i++) begin
			r = 16'($random(seed));
			pin <= r[7:4];
			cmd(1'b1, LNS_ADDR_SHADOW, {1'b0, 5'h0f, r[9:0]});
			cmd(1'b1, LNS_ADDR_SHADOW, sh(5'h0f, ~r[7:0]) | 16'h8000);
			cmd(1'b0, LNS_ADDR_SHADOW, 16'h0000);
			chk("pin control", rdat & 16'hfcff, sh(5'h0f, {r[7:4], ~r[3:0]}));
			chk("pin outputs", {4'h0, o4, o3, odis}, {12'h0f0, ~r[3:0]});
		end
		cmd(1'b1, LNS_ADDR_SHADOW, {1'b0, 5'h01, r[9:0]});
		cmd(1'b1, LNS_ADDR_SHADOW, {1'b1, 5'h01, r[9:0]});
		cmd(1'b0, LNS_ADDR_SHADOW, 16'h0000);
		chk("other code", rdat, 16'h0400);
		cmd(1'b1, LNS_ADDR_SHADOW, {1'b0, 5'h0e, r[9:0]});
		cmd(1'b0, LNS_ADDR_SHADOW, 16'h0000);
		chk("kept source", rdat & 16'hfcff, sh(5'h0e, 8'hf0));
		$display("select test done");
		{rep, mst, men} <= r[13:11];
		cmd(1'b1, LNS_ADDR_SEED, {5'h00, r[10:0]});
		cmd(1'b0, LNS_ADDR_SEED, 16'h0000);
		chk("seed view", rdat, {2'b00, r[13:0]});
		// Generator load must replace the written seed
		@(posedge i_clk);
		ld <= 1'b1;
		ls <= ~r[10:0];
		@(posedge i_clk);
		ld <= 1'b0;
		repeat (2) @(posedge i_clk);
		cmd(1'b0, LNS_ADDR_SEED, 16'h0000);
		chk("seed load", rdat, {2'b00, r[13:11], ~r[10:0]});
		@(posedge i_clk);
		sm <= 1'b1;
		res <= r[5:0];
		nol <= ~r[5:0];
		@(posedge i_clk);
		sm <= 1'b0;
		res <= 6'h00;
		nol <= 6'h00;
		repeat (3) @(posedge i_clk);
		cmd(1'b0, LNS_ADDR_SEED, 16'h0000);
		chk("match set", rdat & 16'h4000, 16'h4000);
		cmd(1'b0, LNS_ADDR_SEED, 16'h0000);
		chk("match clear", rdat & 16'h4000, 16'h0000);
		cmd(1'b1, LNS_ADDR_SEED, 16'hffff);
		cmd(1'b0, LNS_ADDR_SEED, 16'h0000);
		chk("resolution", rdat, {4'h8, r[5:0], ~r[5:0]});
		cmd(1'b0, LNS_ADDR_SEED, 16'h0000);
		chk("res clear", rdat, 16'h8000);
		res <= 6'h3f;
		@(posedge i_clk);
		res <= 6'h00;
		clr <= 1'b1;
		cmd(1'b0, LNS_ADDR_SEED, 16'h0000);
		chk("aneg clear", rdat, 16'h8000);
		$display("status test done");
		complete_run;
	end
endmodule // testbench
`default_nettype wire
